// ==== verilog/tcu_regs.svh ====
// named widths, reset values and timing counts of the three-channel timer
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH

`define TCU_CNT_W 16
`define TCU_CNT_ZERO 16'h0000
`define TCU_CNT_ONE 16'h0001
`define TCU_SVC_ZERO 2'h0
`define TCU_SVC_ONE 2'h1
`define TCU_SVC_LAST 2'h3
`define TCU_PIN_ZERO 2'h0
`define TCU_PIN_IDLE_OUT 1'b1

`endif

// ==== verilog/tcu_pkg.sv ====
// types shared by the timer channels and the timer top
package tcu_pkg;
`include "tcu_regs.svh"

   // ---------------------------------------------------------------
   // channel configuration, held steady by the owning logic
   // ---------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic ext_clk;
      logic prescale;
      logic gate;
      logic dual;
      logic cont;
   } tcu_cfg_s;

   typedef struct packed {
      logic [`TCU_CNT_W-1:0] max_a;
      logic [`TCU_CNT_W-1:0] max_b;
   } tcu_lim_s;

   // gray order along idle, first limit, second limit, done
   typedef enum logic [1:0] {
      TCU_IDLE = 2'h0,
      TCU_RUN_A = 2'h1,
      TCU_RUN_B = 2'h3,
      TCU_DONE = 2'h2
   } tcu_phase_e;
endpackage

// ==== verilog/tcu_channel.sv ====
// one 16-bit timer channel with primary and secondary limit
`timescale 1ns/1ps
`include "tcu_regs.svh"

module tcu_channel (
   input wire logic clock, // cpu clock
   input wire logic rst, // async reset, high
   input tcu_pkg::tcu_cfg_s cfg, // channel mode
   input tcu_pkg::tcu_lim_s lim, // maximum counts
   input wire logic tick, // service slot
   input wire logic src_evt, // external or prescale event pulse
   input wire logic gate_lvl, // gate level
   output logic [`TCU_CNT_W-1:0] count, // count value
   output logic out_lvl, // waveform level
   output logic term // pulse after a limit is reached
);
   import tcu_pkg::*;

   tcu_phase_e phase;
   tcu_phase_e next_phase;
   logic pend;
   logic next_pend;
   logic [`TCU_CNT_W-1:0] next_count;
   logic next_out;
   logic next_term;
   logic running;
   logic step;
   logic wrap;
   logic [`TCU_CNT_W-1:0] lim_act;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      running = (phase == TCU_RUN_A) || (phase == TCU_RUN_B);
      lim_act = (phase == TCU_RUN_B) ? lim.max_b : lim.max_a;
      // an event between slots is held so it is counted at the next slot
      step = tick && running && cfg.en && (!cfg.gate || gate_lvl) &&
             ((!cfg.ext_clk && !cfg.prescale) || pend || src_evt);
      // limit zero means a full 65536 count
      wrap = step && ((count + `TCU_CNT_ONE) == lim_act);
      next_pend = pend;
      if (tick) begin
         next_pend = 1'b0;
      end
      if (src_evt && !tick) begin
         next_pend = 1'b1;
      end
      next_phase = phase;
      next_count = count;
      next_out = out_lvl;
      next_term = wrap;
      case (phase)
         TCU_IDLE: begin
            next_count = `TCU_CNT_ZERO;
            next_out = `TCU_PIN_IDLE_OUT;
            if (cfg.en) begin
               next_phase = TCU_RUN_A;
            end
         end
         TCU_RUN_A, TCU_RUN_B: begin
            if (!cfg.en) begin
               next_phase = TCU_IDLE;
            end else if (wrap) begin
               next_count = `TCU_CNT_ZERO;
               if (cfg.dual) begin
                  next_out = (phase == TCU_RUN_B);
                  if (phase == TCU_RUN_A) begin
                     next_phase = TCU_RUN_B;
                  end else begin
                     next_phase = cfg.cont ? TCU_RUN_A : TCU_DONE;
                  end
               end else begin
                  next_out = 1'b0;
                  next_phase = cfg.cont ? TCU_RUN_A : TCU_DONE;
               end
            end else begin
               if (step) begin
                  next_count = count + `TCU_CNT_ONE;
               end
               // single limit: low for one service period after the limit
               if (tick && !cfg.dual) begin
                  next_out = 1'b1;
               end
            end
         end
         default: begin
            if (!cfg.en) begin
               next_phase = TCU_IDLE;
            end
            // a one-shot single limit must still end its low pulse after one slot
            if (tick && !cfg.dual) begin
               next_out = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase <= TCU_IDLE;
         pend <= 1'b0;
         count <= `TCU_CNT_ZERO;
         out_lvl <= `TCU_PIN_IDLE_OUT;
         term <= 1'b0;
      end else begin
         phase <= next_phase;
         pend <= next_pend;
         count <= next_count;
         out_lvl <= next_out;
         term <= next_term;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   property p_step_count;
      step && !wrap |=> count == $past(count) + `TCU_CNT_ONE;
   endproperty
   a_step_count: assert property (p_step_count)
      else $error("count did not advance by one");

   property p_wrap_zero;
      wrap |=> (count == `TCU_CNT_ZERO) && term;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero)
      else $error("count did not restart from zero at the limit");

   sequence s_first_limit_hit;
      wrap && cfg.dual && (phase == TCU_RUN_A);
   endsequence
   property p_dual_alt;
      s_first_limit_hit |=> (phase == TCU_RUN_B) && !out_lvl;
   endproperty
   a_dual_alt: assert property (p_dual_alt)
      else $error("dual mode did not switch to the second limit");

   property p_out_update;
      wrap && cfg.dual |=> out_lvl != $past(out_lvl);
   endproperty
   a_out_update: assert property (p_out_update)
      else $error("waveform level did not change at the limit");

   property p_one_shot;
      wrap && !cfg.dual && !cfg.cont |=> phase == TCU_DONE ##1 !step;
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("single shot kept running");

   property p_limit_hit;
      step && ((count + `TCU_CNT_ONE) == lim_act) |-> wrap;
   endproperty
   a_limit_hit: assert property (p_limit_hit)
      else $error("limit reached without restart");
endmodule // tcu_channel

// ==== verilog/tcu_timer.sv ====
// three-channel 16-bit timer with pin sync, service divider and dma request
`timescale 1ns/1ps
`include "tcu_regs.svh"

// Behaviour
// - three independent timers, each with a 16-bit count value
// - first and second timer have one input and one output pin; third none
// - first two timers count or time pin events, or make one-shot or duty waveforms
// - third timer serves as internal delay timer and as prescaler for the others
// - third timer can be selected as the dma request source
// - each timer is serviced once every fourth clock
// - pin clock or gate events take effect within six clocks; a gate change here takes up to seven, as pin_lvl lags pin_rise by one clock
// - timer output pin follows its clock input within six clocks
// - every timer has a maximum count at which its count restarts from zero
// - first two timers alternate between primary and secondary maximum counts
// - cpu clock is the 10 mhz system clock times two
module tcu_timer (
   input wire logic clock, // cpu clock, 20 mhz
   input wire logic rst, // async reset, high
   input tcu_pkg::tcu_cfg_s cfg_first, // first timer mode
   input tcu_pkg::tcu_cfg_s cfg_second, // second timer mode
   input tcu_pkg::tcu_cfg_s cfg_third, // third timer mode
   input tcu_pkg::tcu_lim_s lim_first, // first timer limits
   input tcu_pkg::tcu_lim_s lim_second, // second timer limits
   input wire logic [`TCU_CNT_W-1:0] max_third, // third timer limit
   input wire logic dma_sel, // third timer drives dma request
   input wire logic first_in, // first timer input pin
   input wire logic second_in, // second timer input pin
   output logic first_out, // first timer output pin
   output logic second_out, // second timer output pin
   output logic [`TCU_CNT_W-1:0] count_first, // first count
   output logic [`TCU_CNT_W-1:0] count_second, // second count
   output logic [`TCU_CNT_W-1:0] count_third, // third count
   output logic third_done, // third timer limit pulse
   output logic dma_req // dma request pulse
);
   import tcu_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // index 0 is the first timer pin, index 1 the second
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] pin_s3;
   logic [1:0] pin_lvl;
   logic [1:0] next_pin_s1;
   logic [1:0] next_pin_s2;
   logic [1:0] next_pin_s3;
   logic [1:0] next_pin_lvl;
   logic [1:0] pin_agree;
   logic [1:0] pin_rise;

   // a change counts only once stages two and three agree, which filters
   // a metastable settle at the cost of one extra clock of latency
   always_comb begin
      next_pin_s1 = {second_in, first_in};
      next_pin_s2 = pin_s1;
      next_pin_s3 = pin_s2;
      pin_agree = ~(pin_s2 ^ pin_s3);
      next_pin_lvl = (pin_agree & pin_s3) | (~pin_agree & pin_lvl);
      pin_rise = pin_agree & pin_s3 & ~pin_lvl;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1 <= `TCU_PIN_ZERO;
         pin_s2 <= `TCU_PIN_ZERO;
         pin_s3 <= `TCU_PIN_ZERO;
         pin_lvl <= `TCU_PIN_ZERO;
      end else begin
         pin_s1 <= next_pin_s1;
         pin_s2 <= next_pin_s2;
         pin_s3 <= next_pin_s3;
         pin_lvl <= next_pin_lvl;
      end
   end

   // ---------------------------------------------------------------
   // service slot divider
   // ---------------------------------------------------------------
   // the clock input stands for the cpu clock, itself the system clock
   // multiplied up; one service slot every fourth cpu clock caps the count
   // rate at a quarter of the cpu clock
   logic [1:0] svc;
   logic [1:0] next_svc;
   logic tick;

   always_comb begin
      next_svc = svc + `TCU_SVC_ONE;
      tick = (svc == `TCU_SVC_LAST);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         svc <= `TCU_SVC_ZERO;
      end else begin
         svc <= next_svc;
      end
   end

   // ---------------------------------------------------------------
   // third timer: internal only
   // ---------------------------------------------------------------
   tcu_cfg_s cfg_int;
   tcu_lim_s lim_int;
   logic pre_evt;

   // no pin and no secondary limit, so those mode bits are ignored
   always_comb begin
      cfg_int = cfg_third;
      cfg_int.ext_clk = 1'b0;
      cfg_int.prescale = 1'b0;
      cfg_int.gate = 1'b0;
      cfg_int.dual = 1'b0;
      lim_int.max_a = max_third;
      lim_int.max_b = max_third;
   end

   tcu_channel u_third (
      .clock(clock),
      .rst(rst),
      .cfg(cfg_int),
      .lim(lim_int),
      .tick(tick),
      .src_evt(1'b0),
      .gate_lvl(1'b1),
      .count(count_third),
      .out_lvl(),
      .term(pre_evt)
   );

   assign third_done = pre_evt;

   // ---------------------------------------------------------------
   // first and second timers
   // ---------------------------------------------------------------
   logic evt_first;
   logic evt_second;

   // prescale takes the third timer's limit pulse as the count event
   always_comb begin
      evt_first = cfg_first.ext_clk ? pin_rise[0] : pre_evt;
      evt_second = cfg_second.ext_clk ? pin_rise[1] : pre_evt;
   end

   tcu_channel u_first (
      .clock(clock),
      .rst(rst),
      .cfg(cfg_first),
      .lim(lim_first),
      .tick(tick),
      .src_evt(evt_first),
      .gate_lvl(pin_lvl[0]),
      .count(count_first),
      .out_lvl(first_out),
      .term()
   );

   tcu_channel u_second (
      .clock(clock),
      .rst(rst),
      .cfg(cfg_second),
      .lim(lim_second),
      .tick(tick),
      .src_evt(evt_second),
      .gate_lvl(pin_lvl[1]),
      .count(count_second),
      .out_lvl(second_out),
      .term()
   );

   // ---------------------------------------------------------------
   // dma request
   // ---------------------------------------------------------------
   logic next_dma;

   always_comb begin
      next_dma = dma_sel && pre_evt;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dma_req <= 1'b0;
      end else begin
         dma_req <= next_dma;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_gap;
      !tick [*3];
   endsequence
   property p_svc_period;
      tick |=> s_gap ##1 tick;
   endproperty
   a_svc_period: assert property (p_svc_period)
      else $error("service slot not every fourth clock");

   sequence s_first_pin_rise;
      !first_in [*4] ##1 first_in [*3];
   endsequence
   property p_pin_seen;
      s_first_pin_rise |=> pin_rise[0];
   endproperty
   a_pin_seen: assert property (p_pin_seen)
      else $error("first pin edge not seen three clocks after it");

   property p_pin_slot;
      pin_rise[0] |-> ##[0:3] tick;
   endproperty
   a_pin_slot: assert property (p_pin_slot)
      else $error("pin event waited past six clocks for a slot");

   property p_dma;
      pre_evt && dma_sel |=> dma_req;
   endproperty
   a_dma: assert property (p_dma)
      else $error("dma request missing after third timer limit");

   property p_dma_quiet;
      !dma_sel |=> !dma_req;
   endproperty
   a_dma_quiet: assert property (p_dma_quiet)
      else $error("dma request while not selected");

   property p_prescale;
      pre_evt && !cfg_first.ext_clk |-> evt_first;
   endproperty
   a_prescale: assert property (p_prescale)
      else $error("prescale event did not reach first timer");
endmodule // tcu_timer

// ==== bench/tcu_pin_model.sv ====
// pin-side model: event source that drives one timer input pin in bursts
`timescale 1ns/1ps

module tcu_pin_model (
   input wire logic clock, // cpu clock
   input wire logic go, // start a burst
   input wire logic [3:0] half, // clocks per half pulse, 2 or more
   input wire logic [7:0] pulses, // rising edges in the burst
   input wire logic park, // level held between bursts
   output logic pin, // timer input pin
   output logic busy // burst in progress
);
   // ---------------------------------------------------------------
   // burst generator
   // ---------------------------------------------------------------
   // a wider half period plays a slow source; 2 is the fastest legal pace
   initial begin
      pin = 1'b1;
      busy = 1'b0;
      forever begin
         @(negedge clock);
         pin = park;
         if (go) begin
            busy = 1'b1;
            for (int i = 0; i < int'(pulses); i++) begin
               pin = 1'b0;
               repeat (half) @(negedge clock);
               pin = 1'b1;
               repeat (half) @(negedge clock);
            end
            busy = 1'b0;
         end
      end
   end
endmodule // tcu_pin_model

// ==== bench/test_three_channel_timer_pwm.sv ====
// self-checking bench for the three-channel timer
`timescale 1ns/1ps

module test_three_channel_timer_pwm;
   import tcu_pkg::*;
   logic clock, rst, dma_sel, first_in, second_in, first_out, second_out;
   logic third_done, dma_req, go0, go1, park0, park1, busy0, busy1;
   logic [3:0] half;
   logic [7:0] pulses;
   logic [15:0] max_third, count_first, count_second, count_third;
   tcu_cfg_s cfg_first, cfg_second, cfg_third;
   tcu_lim_s lim_first, lim_second;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   tcu_timer dut (.clock(clock), .rst(rst), .cfg_first(cfg_first), .cfg_second(cfg_second),
      .cfg_third(cfg_third), .lim_first(lim_first), .lim_second(lim_second),
      .max_third(max_third), .dma_sel(dma_sel), .first_in(first_in), .second_in(second_in),
      .first_out(first_out), .second_out(second_out), .count_first(count_first),
      .count_second(count_second), .count_third(count_third), .third_done(third_done),
      .dma_req(dma_req));
   tcu_pin_model m_first (.clock(clock), .go(go0), .half(half), .pulses(pulses),
      .park(park0), .pin(first_in), .busy(busy0));
   tcu_pin_model m_second (.clock(clock), .go(go1), .half(half), .pulses(pulses),
      .park(park1), .pin(second_in), .busy(busy1));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [15:0] cnt(input int s);
      return s == 0 ? count_first : (s == 1 ? count_second : count_third);
   endfunction

   task automatic step(input int s, output int gap);
      logic [15:0] prev;
      prev = cnt(s);
      gap = 0;
      do begin
         @(negedge clock);
         gap++;
      end while (cnt(s) === prev && gap < 60);
   endtask

   task automatic idle_all;
      cfg_first = tcu_cfg_s'(6'h00);
      cfg_second = tcu_cfg_s'(6'h00);
      cfg_third = tcu_cfg_s'(6'h00);
      dma_sel = 1'b0;
      repeat (2) @(negedge clock);
   endtask

   // leaves once the model has taken the burst, so latency can be timed
   task automatic burst(input logic who, input logic [3:0] h, input logic [7:0] n);
      half = h;
      pulses = n;
      // non-blocking, so the model takes the request one falling edge later
      go0 <= ~who;
      go1 <= who;
      for (int i = 0; i < 4 && !(busy0 | busy1); i++) @(negedge clock);
      go0 <= 1'b0;
      go1 <= 1'b0;
   endtask

   task automatic hold_len(input logic lvl, output int n);
      n = 0;
      for (int i = 0; i < 40 && second_out !== lvl; i++) @(negedge clock);
      while (second_out === lvl && n < 40) begin
         @(negedge clock);
         n++;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      check(first_out, 1'b1);
      check(second_out, 1'b1);
      check(count_first | count_second | count_third, 16'h0000);
      check({third_done, dma_req}, 2'h0);
   endtask

   // no converter hangs on the first timer's output here, so the bench may use it
   task automatic t_single(input logic [5:0] mode);
      int g;
      idle_all;
      lim_first = '{16'h0003, 16'h0000};
      cfg_first = tcu_cfg_s'(mode);
      step(0, g);
      check(count_first, 16'h0001);
      step(0, g);
      check(16'(g), 16'h0004);
      check(count_first, 16'h0002);
      step(0, g);
      check(count_first, 16'h0000);
      check(first_out, 1'b0);
      repeat (3) @(negedge clock);
      check(first_out, 1'b0);
      @(negedge clock);
      check(first_out, 1'b1);
      // four more slots: a repeating timer ends on two, a single shot stays at zero
      repeat (16) @(negedge clock);
      check(count_first, mode[0] ? 16'h0002 : 16'h0000);
   endtask

   task automatic t_dual;
      int n;
      idle_all;
      lim_second = '{16'h0002, 16'h0003};
      cfg_second = tcu_cfg_s'(6'h23);
      hold_len(1'b0, n);
      check(16'(n), 16'h000C);
      check(count_second, 16'h0000);
      hold_len(1'b1, n);
      check(16'(n), 16'h0008);
   endtask

   task automatic t_third;
      int g;
      int hits;
      idle_all;
      max_third = 16'h0003;
      dma_sel = 1'b1;
      cfg_third = tcu_cfg_s'(6'h21);
      for (int i = 0; i < 20 && third_done !== 1'b1; i++) @(negedge clock);
      check(third_done, 1'b1);
      check(count_third, 16'h0000);
      @(negedge clock);
      check({third_done, dma_req}, 2'h1);
      @(negedge clock);
      check(dma_req, 1'b0);
      lim_first = '{16'h0064, 16'h0000};
      cfg_first = tcu_cfg_s'(6'h29);
      step(0, g);
      step(0, g);
      check(16'(g), 16'h000C);
      dma_sel = 1'b0;
      hits = 0;
      repeat (30) begin
         @(negedge clock);
         hits += int'(dma_req === 1'b1);
      end
      check(16'(hits), 16'h0000);
   endtask

   task automatic t_ext;
      int g;
      idle_all;
      lim_first = '{16'h0064, 16'h0000};
      cfg_first = tcu_cfg_s'(6'h31);
      burst(1'b0, 4'h2, 8'h01);
      // time from the pin's rising edge itself; the timeout guards a lost edge
      @(posedge first_in);
      step(0, g);
      check(16'(g <= 8), 16'h0001);
      burst(1'b0, 4'h2, 8'h05);
      repeat (40) @(negedge clock);
      check(count_first, 16'h0006);
      burst(1'b0, 4'h5, 8'h03);
      repeat (50) @(negedge clock);
      check(count_first, 16'h0009);
      lim_second = '{16'h0001, 16'h0001};
      cfg_second = tcu_cfg_s'(6'h33);
      burst(1'b1, 4'h2, 8'h01);
      @(posedge second_in);
      g = 0;
      while (second_out === 1'b1 && g < 20) begin
         @(negedge clock);
         g++;
      end
      check(16'(g <= 8), 16'h0001);
   endtask

   task automatic t_gate;
      int g;
      park0 = 1'b0;
      idle_all;
      // the low gate level must pass the pin sync before the timer runs
      repeat (3) @(negedge clock);
      lim_first = '{16'h0064, 16'h0000};
      cfg_first = tcu_cfg_s'(6'h25);
      repeat (24) @(negedge clock);
      check(count_first, 16'h0000);
      park0 = 1'b1;
      step(0, g);
      check(16'(g <= 12), 16'h0001);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_count++;
         results;
      end
   end

   initial begin
      rst = 1'b1;
      // both pins idle high, as on a pulled-up input
      {park0, park1, dma_sel} = 3'h6;
      {go0, go1} <= 2'h0;
      half = 4'h2;
      pulses = 8'h00;
      max_third = 16'h0000;
      cfg_first = tcu_cfg_s'(6'h00);
      cfg_second = tcu_cfg_s'(6'h00);
      cfg_third = tcu_cfg_s'(6'h00);
      lim_first = '{16'h0000, 16'h0000};
      lim_second = '{16'h0000, 16'h0000};
      repeat (3) @(negedge clock);
      t_reset;
      rst = 1'b0;
      t_single(6'h21);
      t_single(6'h20);
      t_dual;
      t_third;
      t_ext;
      t_gate;
      results;
   end
endmodule // test_three_channel_timer_pwm
